// [rtl/edr_differential_phase_mapper.v]
// symbol mapper for basic and enhanced rate packets, tx and rx paths
// assumes packet logic presents one symbol per sym_valid_i strobe
// How it works
// [RULE_01] same slot and symbol rate every mode
// [RULE_02] basic rate sends one bit, frequency keying
// [RULE_03] only enhanced payload uses two or three bits; code also phase-keys the sync and trailer fields in enhanced modes
// [RULE_04] two-bit mode: pair picks differential phase change
// [RULE_05] two-bit changes only odd eighths, never half
// [RULE_06] 00 +45, 01 +135, 11 -135, 10 -45
// [RULE_07] two-bit phase alternates between two planes
// [RULE_08] three-bit mode reaches any of eight phases
// [RULE_09] three-bit gray code to phase change table
// [RULE_10] receiver decodes from consecutive phase difference
// [RULE_11] gain set from strength sampled once per slot
// [RULE_12] field order fixed; phase keying after guard
// [RULE_13] accumulator in eighths, modulo turn, packet reset
module edr_differential_phase_mapper #(
  parameter GAIN_HI = 8'hC0, // strength above which gain steps down
  parameter GAIN_LO = 8'h40  // strength below which gain steps up
) (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       tx_start_i,
  input  wire [1:0] tx_mode_i,
  input  wire       tx_sym_valid_i,
  input  wire [2:0] tx_bits_i,
  output wire       tx_sym_ready_o,
  output reg        tx_fsk_o,
  output reg        tx_fsk_bit_o,
  output reg        tx_psk_o,
  output reg  [2:0] tx_phase_o,
  output reg  [2:0] tx_field_o,
  input  wire       tx_field_next_i,
  input  wire       rx_start_i,
  input  wire [1:0] rx_mode_i,
  input  wire       rx_sym_valid_i,
  input  wire [2:0] rx_phase_i,
  output wire       rx_bits_valid_o,
  output wire [2:0] rx_bits_o,
  input  wire [7:0] rssi_i,
  output reg  [2:0] lna_gain_o,
  output reg        sym_strobe_o
);
`include "edr_mapper_map.vh"
  // ****************************************************************
  // state encodings, one hot
  // ****************************************************************
  localparam S_ACCESS  = 6'h01;
  localparam S_HEADER  = 6'h02;
  localparam S_GUARD   = 6'h04;
  localparam S_SYNC    = 6'h08;
  localparam S_PAYLOAD = 6'h10;
  localparam S_TRAILER = 6'h20;

  reg  [5:0] state;       // current packet field
  reg  [5:0] next_state;  // field after advance
  reg  [2:0] acc_phase;   // accumulated tx phase, eighths
  reg  [2:0] next_phase;  // accumulated phase plus change
  reg  [2:0] change;      // mapped phase change
  reg  [1:0] mode;        // mode latched at packet start
  reg  [6:0] sym_cnt;     // clock count within a symbol period
  reg  [9:0] slot_cnt;    // symbols within a slot
  reg        slot_tick;   // one cycle per slot

  // ****************************************************************
  // mapping functions
  // ****************************************************************
  // bit pair to odd eighth change
  function [2:0] map_dqpsk;
    input [1:0] b;
    begin
      case (b)
        2'h0:    map_dqpsk = `PH_P45;  // [RULE_06]
        2'h1:    map_dqpsk = `PH_P135; // [RULE_06]
        2'h3:    map_dqpsk = `PH_M135; // [RULE_06]
        default: map_dqpsk = `PH_M45;  // [RULE_06]
      endcase
    end
  endfunction

  // gray triple to change
  function [2:0] map_8dpsk;
    input [2:0] b;
    begin
      case (b)
        3'h0:    map_8dpsk = `PH_ZERO; // [RULE_09]
        3'h1:    map_8dpsk = `PH_P45;
        3'h3:    map_8dpsk = `PH_P90;
        3'h2:    map_8dpsk = `PH_P135;
        3'h6:    map_8dpsk = `PH_180;
        3'h7:    map_8dpsk = `PH_M135;
        3'h5:    map_8dpsk = `PH_M90;
        default: map_8dpsk = `PH_M45;  // [RULE_09]
      endcase
    end
  endfunction

  // symbols accepted whenever a symbol period elapsed [RULE_01]
  assign tx_sym_ready_o = sym_strobe_o;

  // ****************************************************************
  // symbol timing, common to all modes
  // ****************************************************************
  // one strobe per symbol, one slot tick per slot [RULE_01]
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sym_cnt      <= 7'h00;
      slot_cnt     <= 10'h000;
      sym_strobe_o <= 1'b0;
      slot_tick    <= 1'b0;
    end else begin
      sym_strobe_o <= (sym_cnt == (`SYM_CYCLES - 2));
      slot_tick    <= 1'b0;
      if (sym_cnt == (`SYM_CYCLES - 1)) begin
        sym_cnt <= 7'h00;
        if (slot_cnt == (`SLOT_SYMS - 1)) begin
          slot_cnt  <= 10'h000;
          slot_tick <= 1'b1; // [RULE_01]
        end else begin
          slot_cnt <= slot_cnt + 10'h001;
        end
      end else begin
        sym_cnt <= sym_cnt + 7'h01;
      end
    end
  end

  // ****************************************************************
  // field sequencing
  // ****************************************************************
  // fields advance in fixed order; basic skips guard and sync [RULE_12]
  always @* begin
    next_state = state;
    case (state)
      S_ACCESS:  next_state = S_HEADER;
      S_HEADER:  next_state = (mode == `MODE_BASIC) ? S_PAYLOAD : S_GUARD; // [RULE_12]
      S_GUARD:   next_state = S_SYNC;
      S_SYNC:    next_state = S_PAYLOAD;
      S_PAYLOAD: next_state = (mode == `MODE_BASIC) ? S_PAYLOAD : S_TRAILER;
      S_TRAILER: next_state = S_TRAILER;
      default:   next_state = S_ACCESS;
    endcase
  end

  // change chosen from payload mode
  always @* begin
    change = `PH_ZERO;
    case (mode)
      `MODE_DQPSK: change = map_dqpsk(tx_bits_i[1:0]); // [RULE_04] [RULE_05]
      `MODE_8DPSK: change = map_8dpsk(tx_bits_i);      // [RULE_08]
      default:     change = `PH_ZERO;
    endcase
    next_phase = acc_phase + change; // modulo a turn by width [RULE_13]
  end

  // ****************************************************************
  // transmit mapping
  // ****************************************************************
  // fsk for all but enhanced guard to trailer; phase accumulates
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state        <= S_ACCESS;
      mode         <= `MODE_BASIC;
      acc_phase    <= `PH_RESET;
      tx_fsk_o     <= 1'b0;
      tx_fsk_bit_o <= 1'b0;
      tx_psk_o     <= 1'b0;
      tx_phase_o   <= `PH_RESET;
      tx_field_o   <= `FLD_ACCESS;
    end else begin
      tx_fsk_o <= 1'b0;
      tx_psk_o <= 1'b0;
      if (tx_start_i) begin
        // new packet, phase back to zero [RULE_13]
        state      <= S_ACCESS;
        mode       <= tx_mode_i;
        acc_phase  <= `PH_RESET;
        tx_phase_o <= `PH_RESET;
        tx_field_o <= `FLD_ACCESS;
      end else begin
        if (tx_field_next_i) begin
          state <= next_state; // [RULE_12]
          case (next_state)
            S_HEADER:  tx_field_o <= `FLD_HEADER;
            S_GUARD:   tx_field_o <= `FLD_GUARD;
            S_SYNC:    tx_field_o <= `FLD_SYNC;
            S_PAYLOAD: tx_field_o <= `FLD_PAYLOAD;
            S_TRAILER: tx_field_o <= `FLD_TRAILER;
            default:   tx_field_o <= `FLD_ACCESS;
          endcase
        end
        if (tx_sym_valid_i && sym_strobe_o) begin
          case (state)
            S_ACCESS, S_HEADER: begin
              // one bit per symbol, frequency keying [RULE_02] [RULE_03]
              tx_fsk_o     <= 1'b1;
              tx_fsk_bit_o <= tx_bits_i[0];
            end
            S_GUARD: begin
              // guard carries no symbols; keying switch follows [RULE_12]
              tx_fsk_o <= 1'b0;
            end
            S_SYNC, S_PAYLOAD, S_TRAILER: begin
              if (mode == `MODE_BASIC) begin
                tx_fsk_o     <= 1'b1; // [RULE_02]
                tx_fsk_bit_o <= tx_bits_i[0];
              end else begin
                // in two-bit mode plane alternates since each change is odd [RULE_07]
                tx_psk_o   <= 1'b1; // [RULE_03]
                acc_phase  <= next_phase; // [RULE_13]
                tx_phase_o <= next_phase;
              end
            end
            default: tx_fsk_o <= 1'b0;
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // receive gain control
  // ****************************************************************
  // one strength sample per slot steps the gain [RULE_11]
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lna_gain_o <= `GAIN_RESET;
    end else if (slot_tick) begin
      if (rssi_i > GAIN_HI && lna_gain_o != `GAIN_MIN) begin
        lna_gain_o <= lna_gain_o - 3'h1; // [RULE_11]
      end else if (rssi_i < GAIN_LO && lna_gain_o != `GAIN_MAX) begin
        lna_gain_o <= lna_gain_o + 3'h1; // [RULE_11]
      end
    end
  end

  // ****************************************************************
  // receive decode
  // ****************************************************************
  // differential decoder on received phases
  phase_diff_decoder u_dec (
    .clk_sys_i    (clk_sys_i),
    .reset_n_i    (reset_n_i),
    .sym_valid_i  (rx_sym_valid_i),
    .start_i      (rx_start_i),
    .mode_i       (rx_mode_i),
    .phase_i      (rx_phase_i),
    .bits_valid_o (rx_bits_valid_o),
    .bits_o       (rx_bits_o)
  );
endmodule

// [rtl/edr_mapper_map.vh]
// constants for the symbol mapper: modes, field codes, phase codes, timing
// assumes one symbol per clock enable strobe from the packet logic
`ifndef EDR_MAPPER_MAP_VH
`define EDR_MAPPER_MAP_VH
// ****************************************************************
// rates and timing
// ****************************************************************
`define SYM_RATE_KHZ      1000
`define SLOT_RATE_HZ      1600
`define CLK_RATE_KHZ      100000
// clock cycles per symbol at the common symbol rate
`define SYM_CYCLES        (`CLK_RATE_KHZ / `SYM_RATE_KHZ)
// symbols per slot (625 us)
`define SLOT_SYMS         ((`SYM_RATE_KHZ * 1000) / `SLOT_RATE_HZ)
// ****************************************************************
// payload modes
// ****************************************************************
`define MODE_BASIC        2'h0
`define MODE_DQPSK        2'h1
`define MODE_8DPSK        2'h2
// ****************************************************************
// packet field codes
// ****************************************************************
`define FLD_ACCESS        3'h0
`define FLD_HEADER        3'h1
`define FLD_GUARD         3'h2
`define FLD_SYNC          3'h3
`define FLD_PAYLOAD       3'h4
`define FLD_TRAILER       3'h5
// ****************************************************************
// phase in eighths of a turn
// ****************************************************************
`define PH_RESET          3'h0
`define PH_P45            3'h1
`define PH_P90            3'h2
`define PH_P135           3'h3
`define PH_180            3'h4
`define PH_M135           3'h5
`define PH_M90            3'h6
`define PH_M45            3'h7
`define PH_ZERO           3'h0
// ****************************************************************
// gain control
// ****************************************************************
`define GAIN_RESET        3'h4
`define GAIN_MAX          3'h7
`define GAIN_MIN          3'h0
`endif

// [rtl/phase_diff_decoder.v]
// receive side: recovers bits from phase difference of consecutive symbols
// assumes a quantised phase in eighths of a turn, one per symbol strobe
module phase_diff_decoder (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire       sym_valid_i,
  input  wire       start_i,
  input  wire [1:0] mode_i,
  input  wire [2:0] phase_i,
  output reg        bits_valid_o,
  output reg  [2:0] bits_o
);
`include "edr_mapper_map.vh"
  reg  [2:0] last_phase;   // previous symbol phase
  reg        ref_wait;     // next symbol only sets the phase reference
  wire [2:0] diff;         // phase change, modulo a turn

  assign diff = phase_i - last_phase;

  // ****************************************************************
  // inverse mapping functions
  // ****************************************************************
  // two-bit change to bit pair
  function [1:0] dqpsk_bits;
    input [2:0] d;
    begin
      case (d)
        `PH_P45:  dqpsk_bits = 2'h0;
        `PH_P135: dqpsk_bits = 2'h1;
        `PH_M135: dqpsk_bits = 2'h3;
        `PH_M45:  dqpsk_bits = 2'h2;
        default:  dqpsk_bits = 2'h0; // illegal change, decoded as pair 00
      endcase
    end
  endfunction

  // three-bit change to gray triple
  function [2:0] dpsk8_bits;
    input [2:0] d;
    begin
      case (d)
        `PH_ZERO: dpsk8_bits = 3'h0;
        `PH_P45:  dpsk8_bits = 3'h1;
        `PH_P90:  dpsk8_bits = 3'h3;
        `PH_P135: dpsk8_bits = 3'h2;
        `PH_180:  dpsk8_bits = 3'h6;
        `PH_M135: dpsk8_bits = 3'h7;
        `PH_M90:  dpsk8_bits = 3'h5;
        default:  dpsk8_bits = 3'h4;
      endcase
    end
  endfunction

  // differential decode, no absolute carrier phase needed [RULE_10]
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_phase   <= `PH_RESET;
      ref_wait     <= 1'b1;
      bits_valid_o <= 1'b0;
      bits_o       <= 3'h0;
    end else begin
      // first symbol of a packet has no predecessor, so it yields no bits
      bits_valid_o <= sym_valid_i & ~start_i & ~ref_wait;
      if (sym_valid_i) begin
        ref_wait <= 1'b0; // reference taken
      end else if (start_i) begin
        ref_wait <= 1'b1; // new packet, wait for reference
      end
      if (sym_valid_i) begin
        last_phase <= phase_i;
        case (mode_i)
          `MODE_DQPSK: bits_o <= {1'b0, dqpsk_bits(diff)}; // [RULE_10]
          `MODE_8DPSK: bits_o <= dpsk8_bits(diff);         // [RULE_10]
          default:     bits_o <= 3'h0;
        endcase
      end
    end
  end
endmodule

// [test/edr_mapper_props.sv]
// checker for the symbol mapper: timing and mapping relations at its ports
// assumes one clock, async active-low reset, phase in eighths of a turn
module edr_mapper_props (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       tx_start_i,
  input wire logic [1:0] tx_mode_i,
  input wire logic       tx_sym_valid_i,
  input wire logic [2:0] tx_bits_i,
  input wire logic       tx_fsk_o,
  input wire logic       tx_psk_o,
  input wire logic [2:0] tx_phase_o,
  input wire logic [2:0] tx_field_o,
  input wire logic       tx_field_next_i,
  input wire logic       rx_start_i,
  input wire logic       rx_sym_valid_i,
  input wire logic       rx_bits_valid_o,
  input wire logic [2:0] lna_gain_o,
  input wire logic       sym_strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ****************************************************************
  // helper state
  // ****************************************************************
  logic [1:0] cur_mode;   // mode latched at packet start
  logic [2:0] prev_bits;  // bits one cycle back
  logic [2:0] prev_phase; // phase one cycle back
  wire  [2:0] step_dq = {prev_bits[1], ^prev_bits[1:0], 1'b1};
  wire  [2:0] step_8  = {prev_bits[2], ^prev_bits[2:1], ^prev_bits};
  // latch mode, keep last bits and phase
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_mode   <= 2'h0;
      prev_bits  <= 3'h0;
      prev_phase <= 3'h0;
    end else begin
      if (tx_start_i) cur_mode <= tx_mode_i;
      prev_bits  <= tx_bits_i;
      prev_phase <= tx_phase_o;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  strobe_period_a:
    assert property (sym_strobe_o |-> ##100 sym_strobe_o)
    else $error("symbol strobe spacing wrong");
  strobe_pulse_a:
    assert property (sym_strobe_o |=> !sym_strobe_o [*8])
    else $error("symbol strobe wider than one cycle");
  fsk_cause_a:
    assert property (tx_fsk_o |-> $past(sym_strobe_o) && $past(tx_sym_valid_i))
    else $error("fsk symbol without a taken request");
  symbol_answer_a:
    assert property (sym_strobe_o && tx_sym_valid_i && !tx_start_i && tx_field_o != 3'h2
      |=> tx_fsk_o || tx_psk_o)
    else $error("taken symbol produced nothing");
  guard_silent_a:
    assert property (tx_field_o == 3'h2 && !tx_start_i && !tx_field_next_i
      |=> !tx_fsk_o && !tx_psk_o)
    else $error("symbol sent in guard field");
  psk_field_a:
    assert property (tx_psk_o |-> $past(tx_field_o) >= 3'h3 && cur_mode != 2'h0)
    else $error("phase symbol outside enhanced payload part");
  dqpsk_step_a:
    assert property (tx_psk_o && cur_mode == 2'h1 |-> tx_phase_o == prev_phase + step_dq)
    else $error("two-bit phase step wrong");
  psk8_step_a:
    assert property (tx_psk_o && cur_mode == 2'h2 |-> tx_phase_o == prev_phase + step_8)
    else $error("three-bit phase step wrong");
  rx_cause_a:
    assert property (rx_bits_valid_o |-> $past(rx_sym_valid_i) && !$past(rx_start_i))
    else $error("rx bits without a received symbol");
  gain_step_a:
    assert property ($changed(lna_gain_o) |-> lna_gain_o == $past(lna_gain_o) + 3'h1
      || lna_gain_o == $past(lna_gain_o) - 3'h1)
    else $error("gain moved by more than one step");
endmodule
bind edr_differential_phase_mapper edr_mapper_props edr_mapper_props_inst (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tx_start_i(tx_start_i),
  .tx_mode_i(tx_mode_i), .tx_sym_valid_i(tx_sym_valid_i), .tx_bits_i(tx_bits_i),
  .tx_fsk_o(tx_fsk_o), .tx_psk_o(tx_psk_o), .tx_phase_o(tx_phase_o),
  .tx_field_o(tx_field_o), .tx_field_next_i(tx_field_next_i), .rx_start_i(rx_start_i),
  .rx_sym_valid_i(rx_sym_valid_i), .rx_bits_valid_o(rx_bits_valid_o),
  .lna_gain_o(lna_gain_o), .sym_strobe_o(sym_strobe_o));

// [test/rf_loop_model.sv]
// front-end model: hands each transmitted phase back as a received symbol
// assumes inputs settle by the falling edge of the clock
module rf_loop_model (
  input  wire logic       clk_sys_i,
  input  wire logic       psk_seen_i,
  input  wire logic [2:0] phase_seen_i,
  output logic            sym_valid_o,
  output logic [2:0]      phase_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sym_valid_o = 1'b0;
    phase_o     = 3'h0;
  end
  // loop phase back; between symbols the phase line keeps toggling
  always @(negedge clk_sys_i) begin
    sym_valid_o <= psk_seen_i;
    phase_o     <= psk_seen_i ? phase_seen_i : ~phase_o;
  end
endmodule

// [test/tb.sv]
// bench for the symbol mapper: packets in all modes, rx loop, gain control
// assumes the checker is bound to the mapper
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, tx_start_i = 1'b0, tx_sym_valid_i = 1'b0;
  logic tx_field_next_i = 1'b0, rx_start_i = 1'b0, rx_sym_valid_i;
  logic [1:0] tx_mode_i = 2'h0, rx_mode_i = 2'h0;
  logic [2:0] tx_bits_i = 3'h0, rx_phase_i, tx_phase_o, tx_field_o, rx_bits_o, lna_gain_o;
  logic [7:0] rssi_i = 8'hFF; // strong signal: gain must step down
  logic tx_sym_ready_o, tx_fsk_o, tx_fsk_bit_o, tx_psk_o, rx_bits_valid_o, sym_strobe_o;
  logic [2:0] exp_phase;
  int bad_count = 0, checks = 0, cycles = 0;
  localparam logic [2:0] DQ [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
  localparam logic [2:0] P8 [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4, 3'h5};
  always #5 clk_sys_i = ~clk_sys_i;
  edr_differential_phase_mapper edr_differential_phase_mapper_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .tx_start_i(tx_start_i),
    .tx_mode_i(tx_mode_i), .tx_sym_valid_i(tx_sym_valid_i), .tx_bits_i(tx_bits_i),
    .tx_sym_ready_o(tx_sym_ready_o), .tx_fsk_o(tx_fsk_o), .tx_fsk_bit_o(tx_fsk_bit_o),
    .tx_psk_o(tx_psk_o), .tx_phase_o(tx_phase_o), .tx_field_o(tx_field_o),
    .tx_field_next_i(tx_field_next_i), .rx_start_i(rx_start_i), .rx_mode_i(rx_mode_i),
    .rx_sym_valid_i(rx_sym_valid_i), .rx_phase_i(rx_phase_i),
    .rx_bits_valid_o(rx_bits_valid_o), .rx_bits_o(rx_bits_o), .rssi_i(rssi_i),
    .lna_gain_o(lna_gain_o), .sym_strobe_o(sym_strobe_o));
  rf_loop_model rf_loop_model_inst (.clk_sys_i(clk_sys_i), .psk_seen_i(tx_psk_o),
    .phase_seen_i(tx_phase_o), .sym_valid_o(rx_sym_valid_i), .phase_o(rx_phase_i));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task start_pkt(input logic [1:0] m);
    tx_mode_i = m; rx_mode_i = m; tx_start_i = 1'b1; rx_start_i = 1'b1;
    @(negedge clk_sys_i);
    tx_start_i = 1'b0; rx_start_i = 1'b0; exp_phase = 3'h0;
  endtask
  task next_field();
    tx_field_next_i = 1'b1;
    @(negedge clk_sys_i);
    tx_field_next_i = 1'b0;
    @(negedge clk_sys_i);
  endtask
  // offer bits in the strobe cycle; returns when the answer is visible
  task send(input logic [2:0] b);
    int n;
    n = 0;
    while (sym_strobe_o !== 1'b1 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(tx_sym_ready_o, 1'b1, "no symbol slot offered");
    tx_bits_i = b; tx_sym_valid_i = 1'b1;
    @(negedge clk_sys_i);
    tx_sym_valid_i = 1'b0;
  endtask
  // eight phase symbols from sync onward, looped back to the receiver
  task psk_run(input logic [1:0] m);
    logic [2:0] b;
    for (int i = 0; i < 8; i++) begin
      b = (m == 2'h1) ? {1'b0, i[1:0]} : i[2:0];
      send(b);
      exp_phase = exp_phase + ((m == 2'h1) ? DQ[b[1:0]] : P8[b]);
      check(tx_psk_o, 1'b1, "phase symbol missing");
      check(tx_phase_o, exp_phase, "phase wrong");
      if (m == 2'h1) check(tx_phase_o[0], {7'h00, ~i[0]}, "plane wrong");
      @(negedge clk_sys_i);
      if (i > 0) check({rx_bits_valid_o, rx_bits_o}, {1'b1, b}, "rx bits");
      else check(rx_bits_valid_o, 1'b0, "reference symbol decoded");
      if (i == 1 || i == 5) next_field();
    end
    check(tx_field_o, 3'h5, "trailer field");
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task test_basic();
    start_pkt(2'h0);
    send(3'h1);
    check({tx_fsk_o, tx_fsk_bit_o, tx_psk_o}, 3'h6, "access fsk");
    next_field();
    next_field();
    send(3'h6);
    check({tx_fsk_o, tx_fsk_bit_o, tx_psk_o}, 3'h4, "payload fsk");
    check(tx_field_o, 3'h4, "basic payload field");
    $display("basic rate test done");
  endtask
  task test_dqpsk();
    start_pkt(2'h1);
    next_field();
    send(3'h1);
    check({tx_fsk_o, tx_psk_o}, 2'h2, "header must be fsk");
    next_field();
    send(3'h0);
    check({tx_fsk_o, tx_psk_o}, 2'h0, "guard must be silent");
    next_field();
    check(tx_field_o, 3'h3, "sync field");
    psk_run(2'h1);
    $display("two-bit test done");
  endtask
  task test_8dpsk();
    start_pkt(2'h2);
    repeat (3) next_field();
    psk_run(2'h2);
    $display("three-bit test done");
  endtask
  task test_gain();
    while (cycles < 62700) @(negedge clk_sys_i);
    check(lna_gain_o, 3'h3, "gain after one slot");
    $display("gain test done");
  endtask
  // cut a hang short
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      $display("CHECK FAILED %0t timeout", $time);
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(negedge clk_sys_i);
    check({lna_gain_o, tx_psk_o, tx_fsk_o}, 5'h10, "reset values");
    reset_n_i = 1'b1;
    test_basic();
    test_dqpsk();
    test_8dpsk();
    test_gain();
    print_verdict();
  end
endmodule
